// file: hw/pic_pkg.sv
// Purpose: Constants for the indicator output control block.
// Assumes: 100 MHz core clock; 16-bit configuration registers.
// Notes: Offsets are register indices on the plain register port.
// Notes on behaviour
// - Indicator zero source codes 0x0 to 0x4
// - Codes 0x5 to 0x9 show link speed
// - 0xD any error, 0xE receive error, 0xC none
// - One code: steady link, blink on activity
// - Other three source fields share code table
// - Polarity bits; default from strap, else high
// - Aux force enable bit 12, value 13
// - Indicators two and one force bits
// - Indicator zero force enable 0, value 1
// - Blink rate field: 20, 10, 5, 2 Hz
// - Bypass bit disables event stretching
package pic_pkg;
    // Register indices
    localparam logic [4:0]  SRC_SEL_ADDR  = 5'h18;
    localparam logic [4:0]  POL_FRC_ADDR  = 5'h19;
    localparam logic [4:0]  BLINK_ADDR    = 5'h1A;
    // Reset values
    localparam logic [15:0] SRC_SEL_RST   = 16'h6150;
    localparam logic [15:0] POL_FRC_RST   = 16'h4444;
    localparam logic [2:0]  BLINK_RST     = 3'h2;
    // Writable bits
    localparam logic [15:0] POL_FRC_MASK  = 16'h7777;
    // Field positions inside one indicator nibble, and the bypass bit of the blink register
    localparam int          FRC_EN_BIT    = 0;
    localparam int          FRC_VAL_BIT   = 1;
    localparam int          POL_BIT       = 2;
    localparam int          BYPASS_BIT    = 2;
    // Source codes
    localparam logic [3:0]  SRC_LINK      = 4'h0;
    localparam logic [3:0]  SRC_ACT       = 4'h1;
    localparam logic [3:0]  SRC_TX_ACT    = 4'h2;
    localparam logic [3:0]  SRC_RX_ACT    = 4'h3;
    localparam logic [3:0]  SRC_COL       = 4'h4;
    localparam logic [3:0]  SRC_1000      = 4'h5;
    localparam logic [3:0]  SRC_100       = 4'h6;
    localparam logic [3:0]  SRC_10        = 4'h7;
    localparam logic [3:0]  SRC_10_100    = 4'h8;
    localparam logic [3:0]  SRC_100_1000  = 4'h9;
    localparam logic [3:0]  SRC_LINK_BLNK = 4'hB;
    localparam logic [3:0]  SRC_NONE      = 4'hC;
    localparam logic [3:0]  SRC_ERR_ANY   = 4'hD;
    localparam logic [3:0]  SRC_ERR_RX    = 4'hE;
    // Speed codes from the core
    localparam logic [1:0]  SPD_10        = 2'h0;
    localparam logic [1:0]  SPD_100       = 2'h1;
    localparam logic [1:0]  SPD_1000      = 2'h2;
    // Blink timing: half of the fastest period is the base tick
    localparam int          CLK_MHZ       = 100;
    localparam int          HALF_TICK_US  = 25000;
    localparam int          TICK_CYC      = HALF_TICK_US * CLK_MHZ;
    // Half periods in ticks for 20, 10, 5, 2 Hz
    localparam logic [3:0]  HALF_20HZ     = 4'h1;
    localparam logic [3:0]  HALF_10HZ     = 4'h2;
    localparam logic [3:0]  HALF_5HZ      = 4'h4;
    localparam logic [3:0]  HALF_2HZ      = 4'hA;
    // Stretch length in blink periods (two edges give one full period)
    localparam logic [1:0]  STRETCH_PER   = 2'h2;
    // Event vector positions
    localparam int          EV_TX         = 0;
    localparam int          EV_RX         = 1;
    localparam int          EV_COL        = 2;
    localparam int          EV_RXER       = 3;
    localparam int          EV_TXER       = 4;
    localparam int          EV_NUM        = 5;
endpackage : pic_pkg

// file: hw/pic_blink_if.sv
// Purpose: Carries the blink timebase between the block's modules.
// Assumes: One clock domain.
// Notes: period_pulse is one cycle at the end of each blink period.
`timescale 1ns/100ps
interface pic_blink_if;
    logic period_pulse;  // End of a full blink period
    logic phase;         // Blink phase, high in second half
    modport src (output period_pulse, output phase);
    modport dst (input period_pulse, input phase);
endinterface : pic_blink_if

// file: hw/pic_blink_gen.sv
// Purpose: Blink timebase with selectable rate.
// Assumes: Rate select is quasi static.
// Notes: A rate change takes effect at the next tick, inside the current half period.
`timescale 1ns/100ps
module pic_blink_gen
#(
    parameter int unsigned TICK_CYCLES = pic_pkg::TICK_CYC
)
(
    input  wire logic       clock_in,
    input  wire logic       sys_rst_in,
    input  wire logic [1:0] rate_in,
    pic_blink_if.src        blink
);
    import pic_pkg::*;
    localparam int TW = $clog2(TICK_CYCLES + 1);
    typedef struct packed {
        logic [TW-1:0] tick;   // Cycles inside one tick
        logic [3:0]    halfs;  // Ticks inside one half period
        logic          phase;  // Current blink phase
        logic          pulse;  // End of period marker
    } pic_bg_state_t;
    pic_bg_state_t st_reg;
    pic_bg_state_t st_next;
    logic [3:0]    limit;      // Selected half period

    // Half period lookup and counting
    always_comb
    begin
        st_next = st_reg;
        st_next.pulse = 1'b0;
        case (rate_in)
            2'h0:    limit = HALF_20HZ;
            2'h1:    limit = HALF_10HZ;
            2'h2:    limit = HALF_5HZ;
            default: limit = HALF_2HZ;
        endcase
        if (st_reg.tick >= TW'(TICK_CYCLES - 1))
        begin
            st_next.tick = '0;
            // Greater-or-equal recovers from a switch to a faster rate mid count
            if (st_reg.halfs >= limit - 4'h1)
            begin
                st_next.halfs = '0;
                st_next.phase = ~st_reg.phase;
                st_next.pulse = st_reg.phase;
            end
            else
                st_next.halfs = st_reg.halfs + 4'h1;
        end
        else
            st_next.tick = st_reg.tick + TW'(1);
    end

    // State register
    always_ff @(posedge clock_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign blink.period_pulse = st_reg.pulse;
    assign blink.phase        = st_reg.phase;

    // Half period never runs past the selected count
    half_bound_a: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        (st_reg.halfs >= limit) |=> (st_reg.halfs == 4'h0 ||
            st_reg.halfs < $past(st_reg.halfs)
            || $past(st_reg.tick) < TW'(TICK_CYCLES - 1)))
        else $error("blink half period overran");
endmodule : pic_blink_gen

// file: hw/pic_stretch.sv
// Purpose: Stretches short core events for visibility.
// Assumes: Events are synchronous to the core clock.
// Notes: Output lags the event by one cycle in both modes.
`timescale 1ns/100ps
module pic_stretch
#(
    parameter int N = pic_pkg::EV_NUM
)
(
    input  wire logic         clock_in,
    input  wire logic         sys_rst_in,
    input  wire logic         bypass_in,
    input  wire logic [N-1:0] event_in,
    pic_blink_if.dst          blink,
    output logic      [N-1:0] event_out
);
    import pic_pkg::*;
    typedef struct packed {
        logic [N-1:0][1:0] left;  // Periods still to hold
        logic [N-1:0]      out;   // Stretched events
    } pic_st_state_t;
    pic_st_state_t st_reg;
    pic_st_state_t st_next;

    // Per event hold counters
    always_comb
    begin
        st_next = st_reg;
        for (int i = 0; i < N; i++)
        begin
            if (bypass_in)
            begin
                // Raw pass, counters cleared
                st_next.left[i] = 2'h0;
                st_next.out[i]  = event_in[i];
            end
            else if (event_in[i])
            begin
                // Two period edges guarantee one full period
                st_next.left[i] = STRETCH_PER;
                st_next.out[i]  = 1'b1;
            end
            else
            begin
                if (blink.period_pulse && st_reg.left[i] != 2'h0)
                    st_next.left[i] = st_reg.left[i] - 2'h1;
                st_next.out[i] = (st_next.left[i] != 2'h0);
            end
        end
    end

    // State register
    always_ff @(posedge clock_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign event_out = st_reg.out;

    // Bypass passes each event straight through
    bypass_pass_a: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        bypass_in |=> (event_out == $past(event_in)))
        else $error("bypass did not pass events");
    // A stretched event holds until a period edge at least
    stretch_hold_a: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        (event_in[0] && !bypass_in) ##1 (!event_in[0] && !bypass_in
            && !blink.period_pulse) |=> event_out[0])
        else $error("event stretch ended early");
endmodule : pic_stretch

// file: hw/pic_indicator_ctrl.sv
// Purpose: Indicator output control with source select and force.
// Assumes: Core status inputs are synchronous to clock_in.
// Notes: Pins, read data and all state come from flip-flops.
`timescale 1ns/100ps
module pic_indicator_ctrl
#(
    // Cycles of one 25 ms blink tick, shorten for simulation
    parameter int unsigned TICK_CYCLES = pic_pkg::TICK_CYC
)
(
    input  wire logic        clock_in,
    input  wire logic        sys_rst_in,
    // Register port
    input  wire logic [4:0]  reg_addr_in,
    input  wire logic [15:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [15:0] reg_rdata_out,
    // Polarity straps, one per indicator, 1 = active high
    input  wire logic [3:0]  strap_active_high_in,
    // Core status
    input  wire logic        link_up_in,
    input  wire logic [1:0]  link_speed_in,
    input  wire logic        tx_activity_in,
    input  wire logic        rx_activity_in,
    input  wire logic        collision_in,
    input  wire logic        rx_error_in,
    input  wire logic        tx_error_in,
    // Indicator pins
    output logic             indicator_zero_pin_out,
    output logic             indicator_one_pin_out,
    output logic             indicator_two_pin_out,
    output logic             aux_indicator_pin_out
);
    import pic_pkg::*;

    // Block state outside the blink and stretch modules
    typedef struct packed {
        logic [15:0] indicator_source_select;   // Four source nibbles
        logic [15:0] indicator_polarity_force;  // Level and force bits
        logic [2:0]  blink_cfg;                 // Bypass and rate
        logic        strap_done;                // Straps captured
        logic [15:0] rdata;                     // Read data stage
        logic [3:0]  pins;                      // Pin levels
    } pic_state_t;

    pic_state_t           st_reg;     // Registered state
    pic_state_t           st_next;    // Next state
    logic [EV_NUM-1:0]    raw_ev;     // Events from the core
    logic [EV_NUM-1:0]    str_ev;     // Stretched events
    logic [3:0]           active;     // Indicator states before level
    pic_blink_if          blink ();   // Shared timebase

    // Gather core events in fixed order
    assign raw_ev[EV_TX]   = tx_activity_in;
    assign raw_ev[EV_RX]   = rx_activity_in;
    assign raw_ev[EV_COL]  = collision_in;
    assign raw_ev[EV_RXER] = rx_error_in;
    assign raw_ev[EV_TXER] = tx_error_in;

    // Blink timebase
    pic_blink_gen
    #(
        .TICK_CYCLES (TICK_CYCLES)
    )
    u_blink
    (
        .clock_in    (clock_in),
        .sys_rst_in  (sys_rst_in),
        .rate_in     (st_reg.blink_cfg[1:0]),
        .blink       (blink)
    );

    // Event stretching
    pic_stretch
    #(
        .N           (EV_NUM)
    )
    u_stretch
    (
        .clock_in    (clock_in),
        .sys_rst_in  (sys_rst_in),
        .bypass_in   (st_reg.blink_cfg[BYPASS_BIT]),
        .event_in    (raw_ev),
        .blink       (blink),
        .event_out   (str_ev)
    );

    // Shared source decode, one copy per indicator
    function automatic logic pic_decode
    (
        input logic [3:0]        sel,
        input logic              link,
        input logic [1:0]        spd,
        input logic [EV_NUM-1:0] ev,
        input logic              phase
    );
        logic act;
        act = ev[EV_TX] | ev[EV_RX];
        pic_decode = 1'b0;
        case (sel)
            SRC_LINK:      pic_decode = link;
            SRC_ACT:       pic_decode = act;
            SRC_TX_ACT:    pic_decode = ev[EV_TX];
            SRC_RX_ACT:    pic_decode = ev[EV_RX];
            SRC_COL:       pic_decode = ev[EV_COL];
            // Speed codes need link up as well
            SRC_1000:      pic_decode = link & (spd == SPD_1000);
            SRC_100:       pic_decode = link & (spd == SPD_100);
            SRC_10:        pic_decode = link & (spd == SPD_10);
            SRC_10_100:    pic_decode = link & (spd != SPD_1000);
            SRC_100_1000:  pic_decode = link & (spd != SPD_10);
            // Steady on link, dark half of each blink on activity
            SRC_LINK_BLNK: pic_decode = link & ~(act & phase);
            SRC_ERR_ANY:   pic_decode = ev[EV_RXER] | ev[EV_TXER];
            SRC_ERR_RX:    pic_decode = ev[EV_RXER];
            // Undefined codes, 0xC among them, stay inactive
            default:       pic_decode = 1'b0;
        endcase
    endfunction : pic_decode

    // Source selection for each indicator
    generate
        for (genvar g = 0; g < 4; g++)
        begin : g_sel
            // Same code table for every nibble
            assign active[g] = pic_decode(
                st_reg.indicator_source_select[4*g +: 4],
                link_up_in, link_speed_in, str_ev, blink.phase);
        end
    endgenerate

    // Next state: registers, strap capture, read data and pins
    always_comb
    begin
        logic [3:0] nib;
        logic       lvl;
        nib     = '0;
        lvl     = 1'b0;
        st_next = st_reg;
        // Straps load the level bits once after reset release
        if (!st_reg.strap_done)
        begin
            st_next.strap_done = 1'b1;
            for (int i = 0; i < 4; i++)
                st_next.indicator_polarity_force[4*i + POL_BIT] =
                    strap_active_high_in[i];
        end
        // Register writes, reserved bits held at zero
        if (reg_wr_in)
        begin
            case (reg_addr_in)
                SRC_SEL_ADDR:
                    st_next.indicator_source_select = reg_wdata_in;
                POL_FRC_ADDR:
                    st_next.indicator_polarity_force =
                        reg_wdata_in & POL_FRC_MASK;
                BLINK_ADDR:
                    st_next.blink_cfg = reg_wdata_in[2:0];
                default:
                    st_next.blink_cfg = st_reg.blink_cfg;
            endcase
        end
        // Read data stands only in the cycle after the strobe
        st_next.rdata = 16'h0000;
        if (reg_rd_in)
        begin
            case (reg_addr_in)
                SRC_SEL_ADDR:
                    st_next.rdata = st_reg.indicator_source_select;
                POL_FRC_ADDR:
                    st_next.rdata = st_reg.indicator_polarity_force;
                BLINK_ADDR:
                    st_next.rdata = {13'h0000, st_reg.blink_cfg};
                default:
                    st_next.rdata = 16'h0000;
            endcase
        end
        // Force first, then level, so a forced value obeys polarity
        for (int i = 0; i < 4; i++)
        begin
            nib = st_reg.indicator_polarity_force[4*i +: 4];
            if (nib[FRC_EN_BIT])
                lvl = nib[FRC_VAL_BIT];
            else
                lvl = active[i];
            // Level 0 means the pin is driven low when active
            st_next.pins[i] = nib[POL_BIT] ? lvl : ~lvl;
        end
    end

    // State register
    always_ff @(posedge clock_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            st_reg <= '0;
            st_reg.indicator_source_select  <= SRC_SEL_RST;
            st_reg.indicator_polarity_force <= POL_FRC_RST;
            st_reg.blink_cfg                <= BLINK_RST;
        end
        else
            st_reg <= st_next;
    end

    // Outputs straight from flip-flops
    assign reg_rdata_out          = st_reg.rdata;
    assign indicator_zero_pin_out = st_reg.pins[0];
    assign indicator_one_pin_out  = st_reg.pins[1];
    assign indicator_two_pin_out  = st_reg.pins[2];
    assign aux_indicator_pin_out  = st_reg.pins[3];

    // Indicator zero force drives the pin at its level
    force_zero_a: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        st_reg.indicator_polarity_force[0] |=>
        indicator_zero_pin_out ==
        ~($past(st_reg.indicator_polarity_force[2]) ^
          $past(st_reg.indicator_polarity_force[1])))
        else $error("indicator zero force not applied");
    // Indicator one and two forces
    force_one_two_a: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        (st_reg.indicator_polarity_force[4] &&
         st_reg.indicator_polarity_force[8]) |=>
        indicator_one_pin_out ==
        ~($past(st_reg.indicator_polarity_force[6]) ^
          $past(st_reg.indicator_polarity_force[5])) &&
        indicator_two_pin_out ==
        ~($past(st_reg.indicator_polarity_force[10]) ^
          $past(st_reg.indicator_polarity_force[9])))
        else $error("indicator one or two force not applied");
    // Aux indicator force
    force_aux_a: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        st_reg.indicator_polarity_force[12] |=>
        aux_indicator_pin_out ==
        ~($past(st_reg.indicator_polarity_force[14]) ^
          $past(st_reg.indicator_polarity_force[13])))
        else $error("aux indicator force not applied");
    // Link code follows link state on indicator zero
    link_code_a: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        (st_reg.indicator_source_select[3:0] == SRC_LINK &&
         !st_reg.indicator_polarity_force[0]) |=>
        indicator_zero_pin_out ==
        ~($past(st_reg.indicator_polarity_force[2]) ^
          $past(link_up_in)))
        else $error("link code mismatch");
    // Gigabit-only code on indicator one
    speed_code_a: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        (st_reg.indicator_source_select[7:4] == SRC_1000 &&
         !st_reg.indicator_polarity_force[4]) |=>
        indicator_one_pin_out ==
        ~($past(st_reg.indicator_polarity_force[6]) ^
          ($past(link_up_in) && $past(link_speed_in) == SPD_1000)))
        else $error("speed code mismatch");
    // Undefined code keeps aux inactive
    none_code_a: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        (st_reg.indicator_source_select[15:12] == SRC_NONE &&
         !st_reg.indicator_polarity_force[12]) |=>
        aux_indicator_pin_out ==
        ~$past(st_reg.indicator_polarity_force[14]))
        else $error("code 0xC drove the aux indicator");
    // Blink mode is dark without link
    blink_mode_a: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        (st_reg.indicator_source_select[11:8] == SRC_LINK_BLNK &&
         !st_reg.indicator_polarity_force[8] && !link_up_in) |=>
        indicator_two_pin_out ==
        ~$past(st_reg.indicator_polarity_force[10]))
        else $error("blink mode lit without link");
    // Active low level with a forced one drives the pin low
    level_apply_a: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        (st_reg.indicator_polarity_force[2:0] == 3'h3) |=>
        !indicator_zero_pin_out)
        else $error("polarity not applied after force");
    // Straps set the level bits one cycle after release
    strap_load_a: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        (!st_reg.strap_done && !reg_wr_in) |=>
        st_reg.indicator_polarity_force[6] ==
        $past(strap_active_high_in[1]))
        else $error("strap not captured into level bit");

    // Aux field uses the same code table
    // A slice slip between nibbles shows up here
    aux_table_a: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        (st_reg.indicator_source_select[15:12] == SRC_LINK &&
         !st_reg.indicator_polarity_force[12]) |=>
        aux_indicator_pin_out ==
        ~($past(st_reg.indicator_polarity_force[14]) ^
          $past(link_up_in)))
        else $error("aux field ignored link code");

    // Ten or hundred code on indicator two
    two_speed_a: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        (st_reg.indicator_source_select[11:8] == SRC_10_100 &&
         !st_reg.indicator_polarity_force[8]) |=>
        indicator_two_pin_out ==
        ~($past(st_reg.indicator_polarity_force[10]) ^
          ($past(link_up_in) &&
           $past(link_speed_in) != SPD_1000)))
        else $error("ten or hundred code mismatch");

    // Blink mode lit in the first half with link
    // Phase low is the lit half of each blink
    blink_lit_a: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        (st_reg.indicator_source_select[11:8] == SRC_LINK_BLNK &&
         !st_reg.indicator_polarity_force[8] &&
         link_up_in && !blink.phase) |=>
        indicator_two_pin_out ==
        $past(st_reg.indicator_polarity_force[10]))
        else $error("blink mode dark with link");

    // Level and force read back, reserved bits zero
    frc_read_a: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        (reg_rd_in && reg_addr_in == POL_FRC_ADDR) |=>
        (reg_rdata_out ==
         $past(st_reg.indicator_polarity_force) &&
         (reg_rdata_out & ~POL_FRC_MASK) == 16'h0000))
        else $error("level and force read back wrong");

    // Source select reads back as written
    src_read_a: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        (reg_rd_in && reg_addr_in == SRC_SEL_ADDR) |=>
        reg_rdata_out ==
        $past(st_reg.indicator_source_select))
        else $error("source select read back wrong");

    // Rate and bypass writes land in one cycle
    cfg_write_a: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        (reg_wr_in && reg_addr_in == BLINK_ADDR) |=>
        st_reg.blink_cfg == $past(reg_wdata_in[2:0]))
        else $error("rate and bypass write lost");
endmodule : pic_indicator_ctrl

// file: testbench/pic_lamp_model.sv
// Purpose: Lamps hanging on the four indicator pins.
// Assumes: A lamp glows when its pin sits at the wired active level.
// Notes: Wiring level of each lamp mirrors its polarity strap.
`timescale 1ns/100ps
module pic_lamp_model
(
    input  wire logic [3:0] pin_in,
    input  wire logic [3:0] wired_high_in,
    output logic      [3:0] lit_out
);
    // Lit when the pin level matches the wiring
    assign lit_out = ~(pin_in ^ wired_high_in);
endmodule : pic_lamp_model

// file: testbench/pic_indicator_ctrl_tb.sv
// Purpose: Self-checking bench for the indicator output control.
// Assumes: Short blink tick so blink and stretch fit a brief run.
// Notes: Pin order in vectors is aux, two, one, zero.
`timescale 1ns/100ps
module pic_indicator_ctrl_tb;
    import pic_pkg::*;
    localparam int TICK = 4;   // Shortened blink tick in cycles
    logic        clk, rst, wr, rd, link, tx, rx, col, rxer, txer;
    logic [4:0]  addr;
    logic [15:0] wdata, rdata, cnt;
    logic [1:0]  spd;
    logic [3:0]  strap, pins, lit, prev;
    int          n_mismatch, n_tests;
    logic [15:0] frc [4] = '{16'h7777, 16'h5555, 16'h1111, 16'h7143};
    logic [3:0]  fexp [4] = '{4'hF, 4'h0, 4'hF, 4'hC};
    logic [3:0]  half [4] = '{HALF_20HZ, HALF_10HZ, HALF_5HZ, HALF_2HZ};
    logic [7:0]  core_v [3] = '{8'hB1, 8'hCE, 8'h00};
    logic [15:0] mask [3] = '{16'h2347, 16'h623B, 16'h0000};
    pic_indicator_ctrl #(.TICK_CYCLES(TICK)) pic_indicator_ctrl_i (
        .clock_in(clk), .sys_rst_in(rst), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .strap_active_high_in(strap),
        .link_up_in(link), .link_speed_in(spd), .tx_activity_in(tx),
        .rx_activity_in(rx), .collision_in(col), .rx_error_in(rxer),
        .tx_error_in(txer), .indicator_zero_pin_out(pins[0]),
        .indicator_one_pin_out(pins[1]), .indicator_two_pin_out(pins[2]),
        .aux_indicator_pin_out(pins[3]));
    pic_lamp_model pic_lamp_model_i (.pin_in(pins), .wired_high_in(strap),
        .lit_out(lit));
    // Free running 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk16
    task automatic chk4(input logic [3:0] got, input logic [3:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk4
    // One-cycle write strobe; a gap cycle follows before the next one
    task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a; rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk16(rdata, e);
    endtask : rd_chk
    task automatic core(input logic [7:0] v);
        @(posedge clk);
        {link, spd, tx, rx, col, rxer, txer} <= v;
    endtask : core
    task automatic end_sim;
        $display("compares %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim
    // Watchdog well beyond the expected run of roughly 1150 cycles
    initial
    begin
        #200us;
        n_mismatch++;
        end_sim;
    end
    initial
    begin
        rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = '0; wdata = '0;
        strap = 4'hB; {link, spd, tx, rx, col, rxer, txer} = 8'h00;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd_chk(SRC_SEL_ADDR, SRC_SEL_RST);
        rd_chk(POL_FRC_ADDR, 16'h4044);
        rd_chk(BLINK_ADDR, 16'h0002);
        rd_chk(5'h00, 16'h0000);
        chk4(lit, 4'h0);
        wr_reg(POL_FRC_ADDR, 16'hFFFF);
        rd_chk(POL_FRC_ADDR, 16'h7777);
        $display("test reset and access done");
        // Force values seen through either polarity
        for (int i = 0; i < 4; i++)
        begin
            wr_reg(POL_FRC_ADDR, frc[i]);
            tick(3);
            chk4(pins, fexp[i]);
        end
        $display("test force done");
        // Every code but 0xB with stretch bypassed so events track inputs
        wr_reg(BLINK_ADDR, 16'h0004);
        wr_reg(POL_FRC_ADDR, 16'h4444);
        for (int p = 0; p < 3; p++)
        begin
            core(core_v[p]);
            for (int c = 0; c < 16; c++)
            begin
                if (c == 11)
                    continue;
                wr_reg(SRC_SEL_ADDR, {4{c[3:0]}});
                tick(3);
                chk4(pins, {4{mask[p][c]}});
            end
        end
        $display("test source codes done");
        // Steady link that blinks at each selected rate
        wr_reg(SRC_SEL_ADDR, {4{SRC_LINK_BLNK}});
        core(8'h90);
        for (int r = 0; r < 4; r++)
        begin
            wr_reg(BLINK_ADDR, 16'(r));
            tick(100);
            cnt = '0;
            prev = pins;
            repeat (80)
            begin
                tick(1);
                if (pins[0] !== prev[0])
                    cnt++;
                prev = pins;
            end
            chk16(cnt, 16'(80 / (TICK * half[r])));
        end
        $display("test blink done");
        // Single-cycle event stretched, then gone within five cycles when bypassed
        wr_reg(SRC_SEL_ADDR, {4{SRC_TX_ACT}});
        wr_reg(BLINK_ADDR, 16'h0002);
        core(8'h00);
        tick(10);
        core(8'h10);
        core(8'h00);
        tick(20);
        chk4(pins, 4'hF);
        tick(100);
        chk4(pins, 4'h0);
        wr_reg(BLINK_ADDR, 16'h0006);
        core(8'h10);
        core(8'h00);
        tick(5);
        chk4(pins, 4'h0);
        $display("test stretch done");
        end_sim;
    end
endmodule : pic_indicator_ctrl_tb
